// file: e1_receive_error_counters.sv
// Purpose: E1 receive error counters, clear on read, with sa6 interrupt enables
// Assumes: event strobes are synchronous to clk_i and one cycle long
// Notes: classic Wishbone slave, ack one cycle after the request is seen
//
// Functional notes
// - enable bit 1 gates sa6 others interrupt
// - enable bit 0 gates sa6 all-zeros interrupt
// - count bipolar violations in 12 bits
// - lcv high register bits 3-0, upper zero
// - lcv low register eight bits, clear on read
// - count frame alignment errors in 12 bits
// - fae high register holds upper eight bits
// - fae low register four bits, upper zero
// - 8-bit severely errored frame count, read clears
// - two consecutive fas errors without loss count
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "performance_monitor_defs.svh"
module e1_receive_error_counters (
  // clock and reset
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      ce_i,
  // wishbone slave
  input  wire logic [`PERFORMANCE_MONITOR_ADR_W-1:0]    adr_i,
  input  wire logic [31:0]               dat_i,
  output logic      [31:0]               dat_o,
  input  wire logic                      we_i,
  input  wire logic [3:0]                sel_i,
  input  wire logic                      cyc_i,
  input  wire logic                      stb_i,
  output logic                           ack_o,
  // receive framer events
  input  wire performance_monitor_pkg::rx_events_t      ev_i,
  // interrupt
  output logic                           int_o
);
  // bus and register group
  logic                ack_q;
  logic                ack_d;
  logic [31:0]         dat_q;
  logic [31:0]         dat_d;
  logic [7:0]          en_q;
  logic [7:0]          en_d;
  logic [4:2]          mask_q;
  logic [4:2]          mask_d;
  logic [4:0]          st_q;
  logic [4:0]          st_d;
  logic [4:0]          st_set;
  logic [4:0]          st_clr;
  performance_monitor_pkg::snap_t     lcv_s_q;
  performance_monitor_pkg::snap_t     lcv_s_d;
  performance_monitor_pkg::snap_t     fae_s_q;
  performance_monitor_pkg::snap_t     fae_s_d;
  // framing group
  logic                prev_err_q;
  logic                prev_err_d;
  // counters
  logic [11:0]         lcv_cnt;
  logic [11:0]         fae_cnt;
  logic [7:0]          sef_cnt;
  logic                lcv_clr;
  logic                fae_clr;
  logic                sef_clr;
  logic                lcv_evt;
  logic                fae_evt;
  logic                sef_evt;
  logic                req;
  logic                rd;
  logic [4:0]          mask_eff;

  function automatic logic hit(input logic [`PERFORMANCE_MONITOR_ADR_W-1:0] a, input logic [2:0] idx);
    return (a[`PERFORMANCE_MONITOR_ADR_W-1:`PERFORMANCE_MONITOR_ADR_TOP_LSB] == '0) && (a[`PERFORMANCE_MONITOR_IDX_MSB:`PERFORMANCE_MONITOR_IDX_LSB] == idx);
  endfunction

  // a fresh snapshot is taken unless this half of the current one is still unread
  function automatic logic need_cap(input performance_monitor_pkg::snap_t s, input logic hi);
    return !s.valid || (hi ? s.hi_rd : s.lo_rd);
  endfunction

  function automatic performance_monitor_pkg::snap_t take_half(input performance_monitor_pkg::snap_t s, input logic hi,
                                                input logic [11:0] cnt);
    performance_monitor_pkg::snap_t r;
    r = s;
    if (need_cap(s, hi)) begin
      r.valid = 1'b1;
      r.hi_rd = 1'b0;
      r.lo_rd = 1'b0;
      r.val   = cnt;
    end
    if (hi) begin
      r.hi_rd = 1'b1;
    end else begin
      r.lo_rd = 1'b1;
    end
    if (r.hi_rd && r.lo_rd) begin
      r.valid = 1'b0;
    end
    return r;
  endfunction

  assign req      = cyc_i & stb_i & ~ack_q;
  assign rd       = req & ~we_i;
  assign lcv_evt  = ev_i.bipolar_violation;
  assign fae_evt  = ev_i.fas_strobe & ev_i.fas_error;
  // a pair that the framer flags as causing loss of alignment is not counted
  assign sef_evt  = fae_evt & prev_err_q & ~ev_i.frame_loss;
  assign mask_eff = {mask_q, en_q[`PERFORMANCE_MONITOR_EN_SA6_OTHER], en_q[`PERFORMANCE_MONITOR_EN_SA6_ZERO]};

  always_comb begin
    ack_d   = 1'b0;
    dat_d   = dat_q;
    en_d    = en_q;
    mask_d  = mask_q;
    lcv_s_d = lcv_s_q;
    fae_s_d = fae_s_q;
    lcv_clr = 1'b0;
    fae_clr = 1'b0;
    sef_clr = 1'b0;
    st_clr  = '0;
    st_set  = '0;
    st_set[`PERFORMANCE_MONITOR_ST_SA6_ZERO]  = ev_i.sa6_zero;
    st_set[`PERFORMANCE_MONITOR_ST_SA6_OTHER] = ev_i.sa6_other;
    st_set[`PERFORMANCE_MONITOR_ST_LCV]       = lcv_evt;
    st_set[`PERFORMANCE_MONITOR_ST_FAE]       = fae_evt;
    st_set[`PERFORMANCE_MONITOR_ST_SEF]       = sef_evt;
    if (req) begin
      ack_d = 1'b1;
      dat_d = `PERFORMANCE_MONITOR_RST_DATA;
      if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_HI)) begin
        if (!we_i) begin
          lcv_clr = need_cap(lcv_s_q, 1'b1);
          lcv_s_d = take_half(lcv_s_q, 1'b1, lcv_cnt);
          dat_d   = {28'h0, lcv_s_d.val[`PERFORMANCE_MONITOR_LCV_HI_MSB:`PERFORMANCE_MONITOR_LCV_HI_LSB]};
        end
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_LO)) begin
        if (!we_i) begin
          lcv_clr = need_cap(lcv_s_q, 1'b0);
          lcv_s_d = take_half(lcv_s_q, 1'b0, lcv_cnt);
          dat_d   = {24'h0, lcv_s_d.val[`PERFORMANCE_MONITOR_LCV_LO_MSB:`PERFORMANCE_MONITOR_LCV_LO_LSB]};
        end
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_FAE_HI)) begin
        if (!we_i) begin
          fae_clr = need_cap(fae_s_q, 1'b1);
          fae_s_d = take_half(fae_s_q, 1'b1, fae_cnt);
          dat_d   = {24'h0, fae_s_d.val[`PERFORMANCE_MONITOR_FAE_HI_MSB:`PERFORMANCE_MONITOR_FAE_HI_LSB]};
        end
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_FAE_LO)) begin
        if (!we_i) begin
          fae_clr = need_cap(fae_s_q, 1'b0);
          fae_s_d = take_half(fae_s_q, 1'b0, fae_cnt);
          dat_d   = {28'h0, fae_s_d.val[`PERFORMANCE_MONITOR_FAE_LO_MSB:`PERFORMANCE_MONITOR_FAE_LO_LSB]};
        end
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_SEF)) begin
        if (!we_i) begin
          sef_clr = 1'b1;
          dat_d   = {24'h0, sef_cnt};
        end
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_SA6_EN)) begin
        if (we_i && sel_i[0]) begin
          en_d = dat_i[7:0];
        end
        dat_d = {24'h0, en_q};
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_IRQ_STATUS)) begin
        if (we_i && sel_i[0]) begin
          st_clr = dat_i[4:0];
        end
        dat_d = {27'h0, st_q};
      end else if (hit(adr_i, `PERFORMANCE_MONITOR_IDX_IRQ_MASK)) begin
        // mask bits 1-0 are the sa6 enable bits seen through a second window
        if (we_i && sel_i[0]) begin
          mask_d                  = dat_i[4:2];
          en_d[`PERFORMANCE_MONITOR_EN_SA6_ZERO]  = dat_i[0];
          en_d[`PERFORMANCE_MONITOR_EN_SA6_OTHER] = dat_i[1];
        end
        dat_d = {27'h0, mask_eff};
      end
    end
    // an event in the cycle of its clear is kept
    st_d = (st_q & ~st_clr) | st_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      dat_q   <= `PERFORMANCE_MONITOR_RST_DATA;
      en_q    <= `PERFORMANCE_MONITOR_RST_SA6_EN;
      mask_q  <= `PERFORMANCE_MONITOR_RST_MASK;
      st_q    <= `PERFORMANCE_MONITOR_RST_STATUS;
      lcv_s_q <= '0;
      fae_s_q <= '0;
    end else if (ce_i) begin
      ack_q   <= ack_d;
      dat_q   <= dat_d;
      en_q    <= en_d;
      mask_q  <= mask_d;
      st_q    <= st_d;
      lcv_s_q <= lcv_s_d;
      fae_s_q <= fae_s_d;
    end
  end

  always_comb begin
    prev_err_d = prev_err_q;
    if (ev_i.fas_strobe) begin
      // a counted pair is consumed so a third error does not count twice
      prev_err_d = ev_i.fas_error & ~sef_evt & ~ev_i.frame_loss;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_err_q <= 1'b0;
    end else if (ce_i) begin
      prev_err_q <= prev_err_d;
    end
  end

  sat_counter #(.W(12)) u_lcv (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .inc_i (lcv_evt),
    .clr_i (lcv_clr),
    .cnt_o (lcv_cnt)
  );

  sat_counter #(.W(12)) u_fae (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .inc_i (fae_evt),
    .clr_i (fae_clr),
    .cnt_o (fae_cnt)
  );

  sat_counter #(.W(8)) u_sef (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .inc_i (sef_evt),
    .clr_i (sef_clr),
    .cnt_o (sef_cnt)
  );

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign int_o = |(st_q & mask_eff);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_SA6_OTHER_ON: assert property (st_q[1] && en_q[1] |-> int_o)
    else $error("enabled sa6 others event gave no interrupt");
  AST_SA6_OTHER_OFF: assert property ((st_q == 5'h02) && !en_q[1] |-> !int_o)
    else $error("disabled sa6 others event raised interrupt");
  AST_SA6_ZERO_EN: assert property ((st_q == 5'h01) |-> (int_o == en_q[0]))
    else $error("sa6 all-zeros interrupt not gated by its enable");
  AST_LCV_COUNT: assert property ((ce_i && lcv_evt && !lcv_clr && lcv_cnt != 12'hFFF)
    |=> lcv_cnt == $past(lcv_cnt) + 12'h001)
    else $error("line code violation not counted");
  AST_LCV_HI_READ: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_HI)
    && !lcv_s_q.valid) |=> dat_o == {28'h0, $past(lcv_cnt[11:8])})
    else $error("line code high register read wrong");
  AST_LCV_LO_CLR: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_LO)
    && !lcv_s_q.valid && !lcv_evt) |=> lcv_cnt == 12'h000 ##0 dat_o[31:8] == 24'h0)
    else $error("line code low read did not clear");
  AST_FAE_COUNT: assert property ((ce_i && fae_evt && !fae_clr && fae_cnt != 12'hFFF)
    |=> fae_cnt == $past(fae_cnt) + 12'h001)
    else $error("frame alignment error not counted");
  AST_FAE_HI_READ: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_FAE_HI)
    && !fae_s_q.valid) |=> dat_o == {24'h0, $past(fae_cnt[11:4])})
    else $error("frame alignment high register read wrong");
  AST_FAE_LO_READ: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_FAE_LO)
    && !fae_s_q.valid) |=> dat_o == {28'h0, $past(fae_cnt[3:0])})
    else $error("frame alignment low register read wrong");
  AST_SEF_CLEAR: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_SEF) && !sef_evt)
    |=> sef_cnt == 8'h00 && dat_o == {24'h0, $past(sef_cnt)})
    else $error("severely errored frame read did not clear");
  AST_SEF_EVENT: assert property ((ce_i && ev_i.fas_strobe && ev_i.fas_error && prev_err_q
    && !ev_i.frame_loss && !sef_clr && sef_cnt != 8'hFF) |=> sef_cnt == $past(sef_cnt) + 8'h01)
    else $error("severely errored frame not counted");
  AST_LCV_COHERENT: assert property ((ce_i && rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_LO)
    && lcv_s_q.valid && lcv_s_q.hi_rd) |=> dat_o == {24'h0, $past(lcv_s_q.val[7:0])})
    else $error("second half of line code count not from snapshot");

  COV_SEF: cover property (ce_i && sef_evt);
  COV_INT_CLEARED: cover property (int_o ##1 !int_o);
  COV_LCV_SPLIT_READ: cover property (rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_HI) ##[2:6]
    rd && hit(adr_i, `PERFORMANCE_MONITOR_IDX_LCV_LO));
endmodule // e1_receive_error_counters
`default_nettype wire

// file: e1_receive_error_counters_tb_top.sv
// Purpose: self-checking bench for the receive error counters and sa6 interrupt enables
// Assumes: ack one cycle after a taken request; events counted at the edge they are high
// Notes: a mid-run reset and a clock-enable freeze are tried after the table of reset values
`timescale 1ns/100ps
`default_nettype none
`include "performance_monitor_defs.svh"
module e1_receive_error_counters_tb_top;
  typedef struct packed {
    logic [7:0] adr;
    logic [7:0] exp;
  } row_t;

  localparam logic [5:0] ev_bv  = 6'h20;
  localparam logic [5:0] ev_err = 6'h18;
  localparam logic [5:0] ev_los = 6'h1C;
  localparam logic [5:0] ev_ok  = 6'h10;
  localparam logic [5:0] ev_sz  = 6'h02;
  localparam logic [5:0] ev_so  = 6'h01;

  logic                      clk_i;
  logic                      rst_i;
  logic                      ce_i;
  logic [`PERFORMANCE_MONITOR_ADR_W-1:0]    adr_i;
  logic [31:0]               dat_i;
  logic [31:0]               dat_o;
  logic                      we_i;
  logic [3:0]                sel_i;
  logic                      cyc_i;
  logic                      stb_i;
  logic                      ack_o;
  performance_monitor_pkg::rx_events_t      ev_i;
  logic                      int_o;
  int                        failures;
  int                        checks_done;
  row_t                      rows [10];

  e1_receive_error_counters i_dut (
    .clk_i (clk_i), .rst_i (rst_i), .ce_i (ce_i), .adr_i (adr_i), .dat_i (dat_i),
    .dat_o (dat_o), .we_i (we_i), .sel_i (sel_i), .cyc_i (cyc_i), .stb_i (stb_i),
    .ack_o (ack_o), .ev_i (ev_i), .int_o (int_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic complete_run;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // request is held until the rising edge where ack is seen high; data is taken and the
  // request released at that same edge, so the values read are those before the edge
  task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] wd,
                     output logic [7:0] rdat);
    int n;
    @(posedge clk_i);
    adr_i <= adr;
    we_i  <= we;
    dat_i <= {24'h000000, wd};
    sel_i <= 4'h1;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1) begin
      n++;
      if (n > 16) begin
        failures++;
        $display("CHECK FAILED at %0t: bus answer timed out", $time);
        complete_run();
      end
      @(posedge clk_i);
    end
    rdat = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus({3'h0, idx, 2'h0}, 1'b1, wd, d);
  endtask

  task automatic rd(input logic [2:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] d;
    bus({3'h0, idx, 2'h0}, 1'b0, 8'h00, d);
    check(d, exp, what);
  endtask

  task automatic irq(input logic exp, input string what);
    @(negedge clk_i);
    check({7'h00, int_o}, {7'h00, exp}, what);
  endtask

  // holding an event high for n cycles gives n back-to-back events
  task automatic fire(input logic [5:0] ev, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      ev_i <= performance_monitor_pkg::rx_events_t'(ev);
    end
    @(posedge clk_i);
    ev_i <= '0;
  endtask

  task automatic end_test(input string name);
    $display("test %s done at %0t", name, $time);
  endtask

  initial begin
    logic [7:0] d;
    rst_i = 1'b1; ce_i = 1'b1; adr_i = '0; dat_i = '0; we_i = 1'b0; sel_i = 4'h0;
    cyc_i = 1'b0; stb_i = 1'b0; ev_i = '0; failures = 0; checks_done = 0;
    rows = '{'{8'h00, 8'h00}, '{8'h04, 8'h00}, '{8'h08, 8'h00}, '{8'h0C, 8'h00},
             '{8'h10, 8'h00}, '{8'h14, 8'h00}, '{8'h18, 8'h00}, '{8'h1C, 8'h00},
             '{8'h20, 8'h00}, '{8'hE0, 8'h00}};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    irq(1'b0, "int after reset");
    foreach (rows[i]) begin
      bus(rows[i].adr, 1'b0, 8'h00, d);
      check(d, rows[i].exp, "reset value");
    end
    end_test("reset values");

    wr(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 8'h1C);
    fire(ev_bv, 291);
    irq(1'b1, "lcv interrupt");
    rd(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h04, "lcv status");
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h04);
    irq(1'b0, "lcv status cleared");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h01, "lcv high");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h23, "lcv low");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "lcv high after read");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h00, "lcv low after read");
    end_test("lcv count");

    // low half first, with events arriving between the two halves
    fire(ev_bv, 5);
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h05, "snapshot low");
    fire(ev_bv, 3);
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "snapshot high");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h03, "next interval low");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "next interval high");
    wr(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'hFF);
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h00, "write to count ignored");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "write to count ignored");
    end_test("snapshot");

    fire(ev_bv, 4097);
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h0F, "saturated high");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'hFF, "saturated low");
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h04);
    end_test("saturation");

    // 34 errors make 17 pairs; the pair ending in loss of alignment is not counted
    fire(ev_err, 34);
    fire(ev_err, 1);
    fire(ev_los, 1);
    fire(ev_ok, 1);
    fire(ev_err, 1);
    fire(ev_ok, 1);
    fire(ev_err, 2);
    rd(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h18, "fae and sef status");
    irq(1'b1, "fae interrupt");
    rd(`PERFORMANCE_MONITOR_IDX_FAE_LO, 8'h07, "fae low");
    rd(`PERFORMANCE_MONITOR_IDX_FAE_HI, 8'h02, "fae high");
    rd(`PERFORMANCE_MONITOR_IDX_FAE_HI, 8'h00, "fae high after read");
    rd(`PERFORMANCE_MONITOR_IDX_FAE_LO, 8'h00, "fae low after read");
    rd(`PERFORMANCE_MONITOR_IDX_SEF, 8'h12, "sef count");
    rd(`PERFORMANCE_MONITOR_IDX_SEF, 8'h00, "sef after read");
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h18);
    irq(1'b0, "fae status cleared");
    end_test("frame alignment");

    wr(`PERFORMANCE_MONITOR_IDX_SA6_EN, 8'hA5);
    rd(`PERFORMANCE_MONITOR_IDX_SA6_EN, 8'hA5, "enable read back");
    rd(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 8'h1D, "mask alias");
    fire(ev_sz, 1);
    irq(1'b1, "zeros enabled");
    wr(`PERFORMANCE_MONITOR_IDX_SA6_EN, 8'h00);
    irq(1'b0, "zeros disabled");
    rd(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h01, "zeros status");
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h01);
    fire(ev_so, 1);
    irq(1'b0, "others disabled");
    wr(`PERFORMANCE_MONITOR_IDX_SA6_EN, 8'h02);
    irq(1'b1, "others enabled");
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_STATUS, 8'h02);
    irq(1'b0, "others cleared");
    end_test("sa6 enables");

    // reset in mid-run drops counts, status and mask
    fire(ev_bv, 3);
    irq(1'b1, "lcv interrupt before reset");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    irq(1'b0, "int after second reset");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h00, "lcv low after second reset");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "lcv high after second reset");
    rd(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 8'h00, "mask after second reset");
    end_test("second reset");

    // events while the clock enable is low are not seen at all
    wr(`PERFORMANCE_MONITOR_IDX_IRQ_MASK, 8'h1C);
    @(posedge clk_i);
    ce_i <= 1'b0;
    fire(ev_bv, 4);
    irq(1'b0, "no interrupt while frozen");
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h00, "frozen lcv low");
    fire(ev_bv, 2);
    irq(1'b1, "interrupt after freeze");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_LO, 8'h02, "lcv low after freeze");
    rd(`PERFORMANCE_MONITOR_IDX_LCV_HI, 8'h00, "lcv high after freeze");
    end_test("clock enable");
    complete_run();
  end
endmodule // e1_receive_error_counters_tb_top
`default_nettype wire

// file: performance_monitor_defs.svh
// Purpose: register indices, field positions and reset values of the receive error counters
// Assumes: byte address = 4 * index on a 32-bit classic Wishbone bus
// Notes: definitions only
`ifndef PERFORMANCE_MONITOR_DEFS_SVH
`define PERFORMANCE_MONITOR_DEFS_SVH

// register indices (byte address is four times the index)
`define PERFORMANCE_MONITOR_IDX_LCV_HI     3'h0
`define PERFORMANCE_MONITOR_IDX_LCV_LO     3'h1
`define PERFORMANCE_MONITOR_IDX_FAE_HI     3'h2
`define PERFORMANCE_MONITOR_IDX_FAE_LO     3'h3
`define PERFORMANCE_MONITOR_IDX_SEF        3'h4
`define PERFORMANCE_MONITOR_IDX_SA6_EN     3'h5
`define PERFORMANCE_MONITOR_IDX_IRQ_STATUS 3'h6
`define PERFORMANCE_MONITOR_IDX_IRQ_MASK   3'h7

// bus geometry
`define PERFORMANCE_MONITOR_ADR_W          8
`define PERFORMANCE_MONITOR_IDX_MSB        4
`define PERFORMANCE_MONITOR_IDX_LSB        2
`define PERFORMANCE_MONITOR_ADR_TOP_LSB    5

// count field positions inside the 12-bit counters
`define PERFORMANCE_MONITOR_LCV_HI_MSB     11
`define PERFORMANCE_MONITOR_LCV_HI_LSB     8
`define PERFORMANCE_MONITOR_LCV_LO_MSB     7
`define PERFORMANCE_MONITOR_LCV_LO_LSB     0
`define PERFORMANCE_MONITOR_FAE_HI_MSB     11
`define PERFORMANCE_MONITOR_FAE_HI_LSB     4
`define PERFORMANCE_MONITOR_FAE_LO_MSB     3
`define PERFORMANCE_MONITOR_FAE_LO_LSB     0

// sa6 enable bits and interrupt status/mask bits
`define PERFORMANCE_MONITOR_EN_SA6_ZERO    0
`define PERFORMANCE_MONITOR_EN_SA6_OTHER   1
`define PERFORMANCE_MONITOR_ST_SA6_ZERO    0
`define PERFORMANCE_MONITOR_ST_SA6_OTHER   1
`define PERFORMANCE_MONITOR_ST_LCV         2
`define PERFORMANCE_MONITOR_ST_FAE         3
`define PERFORMANCE_MONITOR_ST_SEF         4

// reset values
`define PERFORMANCE_MONITOR_RST_SA6_EN     8'h00
`define PERFORMANCE_MONITOR_RST_MASK       3'h0
`define PERFORMANCE_MONITOR_RST_STATUS     5'h00
`define PERFORMANCE_MONITOR_RST_DATA       32'h0000_0000

`endif

// file: performance_monitor_pkg.sv
// Purpose: shared types of the receive error counter block
// Assumes: nothing
// Notes: types only, constants live in performance_monitor_defs.svh
package performance_monitor_pkg;

  // event strobes from the receive framer, one clock each
  typedef struct packed {
    logic bipolar_violation;
    logic fas_strobe;
    logic fas_error;
    logic frame_loss;
    logic sa6_zero;
    logic sa6_other;
  } rx_events_t;

  // snapshot of a 12-bit counter split over two byte registers
  typedef struct packed {
    logic        valid;
    logic        hi_rd;
    logic        lo_rd;
    logic [11:0] val;
  } snap_t;

endpackage

// file: sat_counter.sv
// Purpose: saturating event counter with synchronous restart
// Assumes: clr_i and inc_i in the same cycle restart the count at one
// Notes: holds at all ones instead of wrapping
`timescale 1ns/100ps
`default_nettype none
module sat_counter #(
  parameter int W = 12
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // control
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  // count
  output logic [W-1:0]      cnt_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] base;

  always_comb begin
    base  = clr_i ? '0 : cnt_q;
    cnt_d = base;
    if (inc_i && (base != {W{1'b1}})) begin
      cnt_d = base + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign cnt_o = cnt_q;

  AST_SAT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !clr_i && cnt_q == {W{1'b1}}) |=> cnt_q == {W{1'b1}})
    else $error("counter left its saturated value");
endmodule // sat_counter
`default_nettype wire
